// ==== rtl/sadc_pkg.sv ====
package sadc_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 10;     // 100 mhz core clock
    localparam int CONV_TYP_NS    = 290;    // conversion_duration, typical
    localparam int CONV_MAX_NS    = 320;    // conversion_duration, longest
    // longest time divides evenly; typical figure leaves room for the input sync
    localparam int CONV_CYC       = CONV_TYP_NS / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC   = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int DIS_MAX_NS     = 20;     // output release, longest
    localparam int DIS_MAX_CYC    = DIS_MAX_NS / CLK_PERIOD_NS;
    localparam int QUIET1_MIN_NS  = 190;    // post_convert_quiet_time, host side
    localparam int QUIET2_MIN_NS  = 60;     // pre_convert_quiet_time, host side
    localparam int CNVH_MIN_NS    = 10;     // convert_high_width, host side

    // ************************************************************
    // frame layout
    // ************************************************************
    localparam int RES_W          = 18;     // result width, result_top_bit first
    localparam int STAT_W         = 6;      // optional appended status bits
    localparam int FRAME_W        = RES_W + STAT_W;
    localparam int CNT_W          = 5;
    localparam int RX_W           = 16;     // configuration word shifted in
    localparam int RXC_W          = 5;
    localparam int SYNC_W         = 3;

    localparam logic [CNT_W-1:0] BITS_RES   = CNT_W'(RES_W);
    localparam logic [CNT_W-1:0] BITS_FRAME = CNT_W'(FRAME_W);
    localparam logic [CNT_W-1:0] CONV_LOAD  = CNT_W'(CONV_CYC - 1);
    localparam logic [RXC_W-1:0] RX_FULL    = RXC_W'(RX_W);
    localparam logic [STAT_W-1:0] STAT_ZERO = 6'h00;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_CONV,
        SADC_READY
    } sadc_state_t;

    // serial pins as seen by the device
    typedef struct packed {
        logic convert_strobe;
        logic sck;
        logic sdi;
    } sadc_pins_t;

    // sample handed over by the converter core
    typedef struct packed {
        logic [RES_W-1:0]  result;
        logic [STAT_W-1:0] status;
    } sadc_frame_t;

endpackage

// ==== rtl/sadc_sync.sv ====
`timescale 1ns/1ps
module sadc_sync (
    // clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    // asynchronous pins in, synchronised pins out
    input  wire sadc_pkg::sadc_pins_t     i_pins,
    output sadc_pkg::sadc_pins_t          o_pins
);
    import sadc_pkg::*;

    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] meta_d;
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] sync_d;

    // *******************************************************
    // two flops per pin
    // *******************************************************
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_bit
            // first stage only feeds the second stage
            always_comb begin
                meta_d[g] = i_pins[g];
                sync_d[g] = meta_q[g];
            end
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= meta_d[g];
                    sync_q[g] <= sync_d[g];
                end
            end
        end
    endgenerate

    assign o_pins = sync_q;

endmodule

// ==== rtl/sadc_serial.sv ====
`timescale 1ns/1ps
// Contract
// - A rising convert_strobe starts a conversion and picks chip-select or daisy-chain mode.
// - The result is ready for readout no later than 320 ns after convert_strobe rises.
// - In chip-select mode result_top_bit is driven first once convert_strobe or sdi goes low.
// - In chip-select mode sdo is released once convert_strobe and sdi are both high or after the last bit.
// - Each new sdo bit is presented after a falling sck edge for capture on the next edge.
// - On register writes and in daisy-chain mode sdi is sampled on rising sck edges.
module sadc_serial (
    // clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    // serial pins
    input  wire logic                       i_convert_strobe,
    input  wire logic                       i_sck,
    input  wire logic                       i_sdi,
    output logic                            o_sdo,
    output logic                            o_sdo_oe,
    // converter core
    input  wire sadc_pkg::sadc_frame_t      i_frame,
    input  wire logic                       i_status_en,
    output logic                            o_sample,
    output logic                            o_busy,
    // mode and configuration
    output logic                            o_chain_mode,
    output logic [sadc_pkg::RX_W-1:0]       o_rx_word,
    output logic                            o_rx_valid
);
    import sadc_pkg::*;

    // *******************************************************
    // pin synchronisation and edge detection
    // *******************************************************
    sadc_pins_t pins_raw;
    sadc_pins_t pins_s;
    sadc_pins_t pins_p_q;
    sadc_pins_t pins_p_d;

    assign pins_raw = '{convert_strobe: i_convert_strobe, sck: i_sck, sdi: i_sdi};

    sadc_sync u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_pins  (pins_raw),
        .o_pins  (pins_s)
    );

    logic cnv_rise;
    logic sck_rise;
    logic sck_fall;

    // edges taken from the synchronised copy only
    always_comb begin
        pins_p_d = pins_s;
        cnv_rise = pins_s.convert_strobe & ~pins_p_q.convert_strobe;
        sck_rise = pins_s.sck & ~pins_p_q.sck;
        sck_fall = ~pins_s.sck & pins_p_q.sck;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pins_p_q <= '0;
        end else begin
            pins_p_q <= pins_p_d;
        end
    end

    // *******************************************************
    // conversion and readout sequencing
    // *******************************************************
    sadc_state_t          state_q;
    sadc_state_t          state_d;
    logic [CNT_W-1:0]     conv_cnt_q;
    logic [CNT_W-1:0]     conv_cnt_d;
    logic [FRAME_W-1:0]   shift_q;
    logic [FRAME_W-1:0]   shift_d;
    logic [CNT_W-1:0]     bits_q;
    logic [CNT_W-1:0]     bits_d;
    logic                 chain_q;
    logic                 chain_d;
    logic                 pend_q;
    logic                 pend_d;
    logic                 sdo_q;
    logic                 sdo_d;
    logic                 oe_q;
    logic                 oe_d;
    logic                 sample_q;
    logic                 sample_d;
    logic                 busy_q;
    logic                 busy_d;
    logic                 cs_sel;

    // chip-select readout is enabled while convert_strobe or sdi is low
    assign cs_sel = ~pins_s.convert_strobe | ~pins_s.sdi;

    always_comb begin
        state_d    = state_q;
        conv_cnt_d = conv_cnt_q;
        shift_d    = shift_q;
        bits_d     = bits_q;
        chain_d    = chain_q;
        pend_d     = pend_q;
        sample_d   = 1'b0;
        case (state_q)
            SADC_IDLE, SADC_READY: begin
                if (cnv_rise) begin
                    state_d    = SADC_CONV;
                    conv_cnt_d = CONV_LOAD;
                    chain_d    = ~pins_s.sdi;
                    sample_d   = 1'b1;
                    bits_d     = '0;
                end else if (state_q == SADC_READY) begin
                    if (chain_q && sck_rise) begin
                        pend_d = pins_s.sdi;
                    end
                    if (sck_fall && chain_q) begin
                        shift_d = {shift_q[FRAME_W-2:0], pend_q};
                    end else if (sck_fall && cs_sel && bits_q != '0) begin
                        shift_d = {shift_q[FRAME_W-2:0], 1'b0};
                        bits_d  = bits_q - 1'b1;
                    end
                end
            end
            SADC_CONV: begin
                if (conv_cnt_q == '0) begin
                    state_d = SADC_READY;
                    shift_d = {i_frame.result, i_status_en ? i_frame.status : STAT_ZERO};
                    bits_d  = i_status_en ? BITS_FRAME : BITS_RES;
                end else begin
                    conv_cnt_d = conv_cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = SADC_IDLE;
            end
        endcase
        busy_d = (state_d == SADC_CONV);
    end

    // output pin drive, registered
    always_comb begin
        sdo_d = 1'b0;
        oe_d  = 1'b0;
        if (state_d == SADC_READY) begin
            if (chain_d) begin
                sdo_d = shift_d[FRAME_W-1];
                oe_d  = 1'b1;
            end else if (cs_sel && bits_d != '0) begin
                sdo_d = shift_d[FRAME_W-1];
                oe_d  = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q    <= SADC_IDLE;
            conv_cnt_q <= '0;
            shift_q    <= '0;
            bits_q     <= '0;
            chain_q    <= 1'b0;
            pend_q     <= 1'b0;
            sdo_q      <= 1'b0;
            oe_q       <= 1'b0;
            sample_q   <= 1'b0;
            busy_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            conv_cnt_q <= conv_cnt_d;
            shift_q    <= shift_d;
            bits_q     <= bits_d;
            chain_q    <= chain_d;
            pend_q     <= pend_d;
            sdo_q      <= sdo_d;
            oe_q       <= oe_d;
            sample_q   <= sample_d;
            busy_q     <= busy_d;
        end
    end

    // *******************************************************
    // configuration shift-in, chip-select mode
    // *******************************************************
    logic [RX_W-1:0]  rx_sh_q;
    logic [RX_W-1:0]  rx_sh_d;
    logic [RXC_W-1:0] rx_cnt_q;
    logic [RXC_W-1:0] rx_cnt_d;
    logic [RX_W-1:0]  rx_word_q;
    logic [RX_W-1:0]  rx_word_d;
    logic             rx_valid_q;
    logic             rx_valid_d;

    // a frame of exactly RX_W rising edges closes as a word on convert_strobe rise
    always_comb begin
        rx_sh_d    = rx_sh_q;
        rx_cnt_d   = rx_cnt_q;
        rx_word_d  = rx_word_q;
        rx_valid_d = 1'b0;
        if (cnv_rise) begin
            rx_cnt_d = '0;
            if (rx_cnt_q == RX_FULL) begin
                rx_word_d  = rx_sh_q;
                rx_valid_d = 1'b1;
            end
        end else if (sck_rise && !chain_q && !pins_s.convert_strobe) begin
            rx_sh_d = {rx_sh_q[RX_W-2:0], pins_s.sdi};
            if (rx_cnt_q != '1) begin
                rx_cnt_d = rx_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_sh_q    <= '0;
            rx_cnt_q   <= '0;
            rx_word_q  <= '0;
            rx_valid_q <= 1'b0;
        end else begin
            rx_sh_q    <= rx_sh_d;
            rx_cnt_q   <= rx_cnt_d;
            rx_word_q  <= rx_word_d;
            rx_valid_q <= rx_valid_d;
        end
    end

    // outputs straight from flops
    assign o_sdo        = sdo_q;
    assign o_sdo_oe     = oe_q;
    assign o_sample     = sample_q;
    assign o_busy       = busy_q;
    assign o_chain_mode = chain_q;
    assign o_rx_word    = rx_word_q;
    assign o_rx_valid   = rx_valid_q;

endmodule

// ==== verification/sadc_serial_props.sv ====
`timescale 1ns/1ps
module sadc_serial_props (
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    // watched ports
    input  wire logic                  i_convert_strobe,
    input  wire logic                  i_sck,
    input  wire logic                  o_sdo,
    input  wire logic                  o_sdo_oe,
    input  wire sadc_pkg::sadc_frame_t i_frame,
    input  wire logic                  o_sample,
    input  wire logic                  o_busy,
    input  wire logic                  o_chain_mode,
    input  wire logic                  o_rx_valid
);
    import sadc_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ************************************************************
    // serial link checks
    // ************************************************************
    a_conv_start: assert property (
        $rose(i_convert_strobe) && !o_busy |-> ##[3:5] o_sample) else $error("no start");
    a_sample_busy: assert property (
        o_sample |-> o_busy) else $error("sample outside conversion");
    a_conv_len: assert property (
        $rose(o_busy) |-> o_busy[*8] ##[21:23] !o_busy) else $error("conversion length");
    a_first_bit: assert property (
        $rose(o_sdo_oe) && !o_chain_mode |-> o_sdo == i_frame.result[RES_W-1])
        else $error("first bit wrong");
    a_sdo_release: assert property (
        !o_chain_mode && o_sdo_oe && $rose(i_convert_strobe) |-> ##[1:5] !o_sdo_oe)
        else $error("sdo not released");
    a_sdo_hold: assert property (
        o_sdo_oe && $fell(i_sck) |-> $stable(o_sdo)[*2]) else $error("sdo moved at fall");
    a_rx_cause: assert property (
        o_rx_valid |-> $past(i_convert_strobe, 2) && !$past(i_convert_strobe, 7))
        else $error("word without strobe rise");
    a_rx_single: assert property (
        o_rx_valid |=> !o_rx_valid) else $error("word pulse too long");
endmodule
bind sadc_serial sadc_serial_props i_props (.i_clk, .i_rst_n, .i_convert_strobe, .i_sck,
    .o_sdo, .o_sdo_oe, .i_frame, .o_sample, .o_busy, .o_chain_mode, .o_rx_valid);

// ==== verification/sadc_host.sv ====
`timescale 1ns/1ps
module sadc_host (
    // clock
    input  wire logic i_clk,
    // device serial pins
    input  wire logic i_sdo,
    output logic      o_convert_strobe,
    output logic      o_sck,
    output logic      o_sdi
);
    // idle pins: sck still outside frames
    initial begin
        o_convert_strobe = 1'b0;
        o_sck            = 1'b0;
        o_sdi            = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // sdi picks mode, strobe rises and stays high well past 10 ns
    task automatic convert(input logic cs);
        // strobe goes low first so that every call gives a fresh rise
        @(posedge i_clk) o_sdi <= cs;
        o_convert_strobe <= 1'b0;
        wait_clk(2);
        @(posedge i_clk) o_convert_strobe <= 1'b1;
        // sck idle through conversion and quiet time
        wait_clk(36);
    endtask
    // slow sck, no top rate
    // one 80 ns sck period; sdi set while low, sdo taken just before the fall
    task automatic clock_bit(input logic din, output logic dout);
        @(posedge i_clk) o_sdi <= din;
        wait_clk(2);
        @(posedge i_clk) o_sck <= 1'b1;
        wait_clk(3);
        dout = i_sdo;
        @(posedge i_clk) o_sck <= 1'b0;
    endtask
    task automatic read(input int n, input logic drop, input logic [23:0] din,
                        output logic [23:0] q);
        logic b;
        q = '0;
        if (drop) @(posedge i_clk) o_convert_strobe <= 1'b0;
        wait_clk(4);
        for (int i = 0; i < n; i++) begin
            clock_bit(din[n - 1 - i], b);
            q = {q[22:0], b};
        end
        // gap after last fall before next strobe rise
        wait_clk(8);
    endtask
    // config bits offered msb first around rising sck
    task automatic write(input int n, input logic [15:0] w);
        logic b;
        @(posedge i_clk) o_convert_strobe <= 1'b0;
        wait_clk(4);
        for (int i = n - 1; i >= 0; i--) clock_bit(w[i], b);
        wait_clk(8);
    endtask
endmodule

// ==== verification/sadc_serial_tb_top.sv ====
`timescale 1ns/1ps
module sadc_serial_tb_top;
    import sadc_pkg::*;
    logic            i_clk, i_rst_n, i_convert_strobe, i_sck, i_sdi, i_status_en;
    logic            o_sdo, o_sdo_oe, o_sample, o_busy, o_chain_mode, o_rx_valid;
    logic [RX_W-1:0] o_rx_word;
    sadc_frame_t     i_frame;
    int              errors, n_checks, n_rx, nb;
    logic [23:0]     q, d;
    logic [15:0]     w;
    sadc_serial i_dut (.i_clk, .i_rst_n, .i_convert_strobe, .i_sck, .i_sdi, .o_sdo,
        .o_sdo_oe, .i_frame, .i_status_en, .o_sample, .o_busy, .o_chain_mode,
        .o_rx_word, .o_rx_valid);
    // a released sdo floats to its pull-up level
    sadc_host i_host (.i_clk, .i_sdo(o_sdo_oe ? o_sdo : 1'b1), .o_convert_strobe(i_convert_strobe),
        .o_sck(i_sck), .o_sdi(i_sdi));
    // ************************************************************
    // clock, helpers
    // ************************************************************
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (o_rx_valid === 1'b1) n_rx++;
    function automatic logic [23:0] exp_bits(input sadc_frame_t f, input logic en, input int n);
        logic [23:0] full;
        full = en ? {f.result, f.status} : {f.result, 6'h00};
        return full >> (24 - n);
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog: tests need about 25 us
    initial begin
        #200000;
        errors++;
        results();
    end
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        errors = 0;
        n_checks = 0;
        n_rx = 0;
        i_rst_n = 1'b0;
        i_status_en = 1'b0;
        i_frame = 24'h800001;
        void'($urandom(32'hf68e));
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        // cs reads, both frame lengths, corner frame first
        for (int k = 0; k < 6; k++) begin
            nb = (k % 2) ? 24 : 18;
            @(posedge i_clk);
            i_frame     <= (k == 0) ? 24'h800001 : 24'($urandom);
            i_status_en <= 1'(k % 2);
            i_host.convert(1'b1);
            chk(24'(o_chain_mode), 24'h0);
            i_host.read(nb, 1'b1, 24'($urandom), q);
            chk(q, exp_bits(i_frame, i_status_en, nb));
            chk(24'(o_sdo_oe), 24'h0);
        end
        $display("test cs_read done");
        // abort a read by a new strobe rise, then read the new result whole
        i_host.convert(1'b1);
        i_host.read(5, 1'b1, 24'($urandom), q);
        chk(q, exp_bits(i_frame, i_status_en, 5));
        i_host.convert(1'b1);
        chk(24'(o_sdo_oe), 24'h0);
        i_host.read(18, 1'b1, 24'($urandom), q);
        chk(q, exp_bits(i_frame, i_status_en, 18));
        $display("test abort done");
        // config word: 16 bits taken, 15 bits discarded
        w = 16'($urandom);
        i_host.convert(1'b1);
        i_host.write(16, w);
        i_host.convert(1'b1);
        chk(24'(o_rx_word), 24'(w));
        chk(24'(n_rx), 24'h1);
        i_host.write(15, ~w);
        i_host.convert(1'b1);
        chk(24'(n_rx), 24'h1);
        $display("test config done");
        // daisy-chain mode chosen by sdi low at strobe rise
        i_host.convert(1'b0);
        chk(24'(o_chain_mode), 24'h1);
        d = 24'($urandom);
        i_host.read(24, 1'b0, d, q);
        chk(q, exp_bits(i_frame, i_status_en, 24));
        // bits taken in on the first pass come out whole on the second
        i_host.read(24, 1'b0, ~d, q);
        chk(q, d);
        i_host.convert(1'b1);
        chk(24'(o_chain_mode), 24'h0);
        $display("test chain done");
        results();
    end
endmodule
